// >>> sim/cmp_analog_model.sv
// Behavioural analog side: comparator decision with a chosen settling delay
`timescale 1ns/10ps
`default_nettype none
module cmp_analog_model
(
  input  wire logic       level_in,
  input  wire logic [7:0] delay_in,
  output var logic        cmp_out
);
  // No clock here: the decision moves on its own, prompt or slow
  initial cmp_out = 1'b0;
  always @(level_in) cmp_out <= #(delay_in) level_in;
endmodule // cmp_analog_model
`default_nettype wire

// >>> sim/comparator_edge_control_bench.sv
// Self-checking bench for the comparator edge control block
`timescale 1ns/10ps
`default_nettype none
module comparator_edge_control_bench;
  import cmp_edge_pkg::*;
  logic       clk_in = 1'b0, rst_n_in = 1'b0, level = 1'b0, analog, wr_en = 1'b0, rsrc = 1'b1;
  logic [7:0] wr_addr = 8'h00, wr_data = 8'h00, dly = 8'h03, ctl, md;
  logic       pwr, raw, lat, rirq, firq, rreq;
  logic [3:0] h;
  cmp_cfg_t   cfg;
  integer     seed = 56008, miscompares = 0, num_checks = 0, cycles = 0, i;
  always #5 clk_in = ~clk_in;
  cmp_analog_model cmp_analog_model_inst (.level_in(level), .delay_in(dly), .cmp_out(analog));
  comparator_edge_control comparator_edge_control_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .cmp_analog_in(analog), .wr_en_in(wr_en), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
    .cmp_reset_src_en_in(rsrc), .cmp_control_reg_out(ctl), .cmp_mode_reg_out(md),
    .cmp_cfg_out(cfg), .cmp_power_en_out(pwr), .cmp_raw_out(raw), .cmp_latched_out(lat),
    .cmp_rise_irq_out(rirq), .cmp_fall_irq_out(firq), .cmp_reset_req_out(rreq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One write strobe; returns at the falling edge after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(negedge clk_in);
    wr_en = 1'b0;
  endtask
  task automatic settle();
    repeat (6) @(negedge clk_in);
  endtask
  task automatic complete_run();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles > 2000)
    begin
      miscompares++;
      complete_run();
    end
  end
  initial
  begin
    repeat (8) @(negedge clk_in);
    rst_n_in = 1'b1;
    check(ctl, 8'h00);
    check(md, 8'h02);
    check({7'h0, pwr}, 8'h00);
    level = 1'b1;
    settle();
    check({6'h0, raw, lat}, 8'h00);
    wr(8'h9b, 8'h80);
    check({6'h0, pwr, cfg.enable}, 8'h03);
    check({7'h0, raw}, 8'h01);
    settle();
    check({7'h0, lat}, 8'h01);
    check(ctl, 8'he0);
    check({7'h0, rreq}, 8'h00);
    wr(8'h9d, 8'hff);
    check(md, 8'h33);
    check({6'h0, rirq, firq}, 8'h02);
    level = 1'b0;
    #4 check({7'h0, raw}, 8'h00);
    settle();
    check(ctl, 8'hb0);
    check({6'h0, firq, rreq}, 8'h03);
    rsrc = 1'b0;
    @(negedge clk_in);
    check({7'h0, rreq}, 8'h00);
    rsrc = 1'b1;
    wr(8'h9d, 8'h02);
    check({6'h0, rirq, firq}, 8'h00);
    wr(8'h9c, 8'hff);
    check(ctl, 8'hb0);
    check(md, 8'h02);
    for (i = 0; i < 8; i++)
    begin
      h = {i[1:0], 2'($random(seed))};
      wr(8'h9b, {4'hc, h});
      check(ctl, {4'h8, h});
      check({4'h0, cfg.pos_hyst, cfg.neg_hyst}, {4'h0, h});
      wr(8'h9d, {6'h0, i[1:0]});
      check({6'h0, cfg.response_mode}, {6'h0, i[1:0]});
    end
    wr(8'h9b, {4'h8, h});
    check(ctl, {4'h8, h});
    dly = 8'h20;
    level = 1'b1;
    #25 check({7'h0, raw}, 8'h00);
    #9 check({7'h0, raw}, 8'h01);
    settle();
    check(ctl, {4'he, h});
    wr(8'h9b, 8'h00);
    check({6'h0, pwr, raw}, 8'h00);
    settle();
    check({7'h0, lat}, 8'h00);
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    check(ctl, 8'h00);
    check(md, 8'h02);
    complete_run();
  end
endmodule // comparator_edge_control_bench
`default_nettype wire

// >>> src/cmp_edge_defines.svh
// Constants for the comparator edge control block
// ***************************************************
// ***************************************************
`ifndef CMP_EDGE_DEFINES_SVH
`define CMP_EDGE_DEFINES_SVH
`define CMP_CONTROL_ADDR   8'h9b
`define CMP_MODE_ADDR      8'h9d
`define CMP_EN_POS         7
`define CMP_OUT_POS        6
`define CMP_RISE_POS       5
`define CMP_FALL_POS       4
`define CMP_RISE_IE_POS    5
`define CMP_FALL_IE_POS    4
`define CMP_PHYST_HI       3
`define CMP_PHYST_LO       2
`define CMP_NHYST_HI       1
`define CMP_NHYST_LO       0
`define CMP_MODE_HI        1
`define CMP_MODE_LO        0
`define CMP_CONTROL_RESET  8'h00
`define CMP_MODE_RESET     2'h2
`define CMP_HYST_RESET     2'h0
`endif

// >>> src/cmp_edge_pkg.sv
// Types shared by the comparator edge control block
`default_nettype none
package cmp_edge_pkg;
  typedef enum logic [1:0] {hyst_off, hyst_5mv, hyst_10mv, hyst_20mv} hyst_sel_t;
  typedef struct packed {
    logic      enable;
    hyst_sel_t pos_hyst;
    hyst_sel_t neg_hyst;
    logic [1:0] response_mode;
  } cmp_cfg_t;
endpackage
`default_nettype wire

// >>> src/comparator_edge_control.sv
// Comparator control, status, edge flags and output gating
`timescale 1ns/10ps
`default_nettype none
`include "cmp_edge_defines.svh"
module comparator_edge_control
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    cmp_analog_in,
  input  wire logic                    wr_en_in,
  input  wire logic [7:0]              wr_addr_in,
  input  wire logic [7:0]              wr_data_in,
  input  wire logic                    cmp_reset_src_en_in,
  output logic [7:0]                   cmp_control_reg_out,
  output logic [7:0]                   cmp_mode_reg_out,
  output cmp_edge_pkg::cmp_cfg_t       cmp_cfg_out,
  output logic                         cmp_power_en_out,
  output logic                         cmp_raw_out,
  output logic                         cmp_latched_out,
  output logic                         cmp_rise_irq_out,
  output logic                         cmp_fall_irq_out,
  output logic                         cmp_reset_req_out
);
  import cmp_edge_pkg::*;

  // ***************************************************
  // Register state
  // ***************************************************
  logic       cmp_enable_bit;
  logic       cmp_rise_flag;
  logic       cmp_fall_flag;
  hyst_sel_t  cmp_pos_hyst_sel;
  hyst_sel_t  cmp_neg_hyst_sel;
  logic [1:0] cmp_response_mode;
  logic       cmp_rise_irq_en;
  logic       cmp_fall_irq_en;
  logic       next_enable;
  logic       next_rise_flag;
  logic       next_fall_flag;
  hyst_sel_t  next_pos_hyst;
  hyst_sel_t  next_neg_hyst;
  logic [1:0] next_mode;
  logic       next_rise_ie;
  logic       next_fall_ie;
  logic       next_latched;

  // ***************************************************
  // Synchroniser and edge detect
  // ***************************************************
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic rise_evt;
  logic fall_evt;
  logic wr_ctl;
  logic wr_mode;

  // Raw path is pure gating so it keeps working with the clock stopped
  assign cmp_raw_out = cmp_analog_in & cmp_enable_bit;
  assign cmp_power_en_out = cmp_enable_bit;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end
    else
    begin
      // First stage may go metastable; only the later two decide an edge
      sync_a <= cmp_raw_out;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // A change counts once the second and third stages agree
  assign rise_evt = sync_b & sync_c & ~cmp_latched_out;
  assign fall_evt = ~sync_b & ~sync_c & cmp_latched_out;
  // Unmapped addresses match neither decode, so stray writes change nothing
  assign wr_ctl   = wr_en_in && (wr_addr_in == `CMP_CONTROL_ADDR);
  assign wr_mode  = wr_en_in && (wr_addr_in == `CMP_MODE_ADDR);

  // ***************************************************
  // Next-state logic
  // ***************************************************
  always_comb
  begin
    next_enable    = cmp_enable_bit;
    next_rise_flag = cmp_rise_flag;
    next_fall_flag = cmp_fall_flag;
    next_pos_hyst  = cmp_pos_hyst_sel;
    next_neg_hyst  = cmp_neg_hyst_sel;
    next_mode      = cmp_response_mode;
    next_rise_ie   = cmp_rise_irq_en;
    next_fall_ie   = cmp_fall_irq_en;
    if (wr_ctl)
    begin
      next_enable    = wr_data_in[`CMP_EN_POS];
      next_rise_flag = wr_data_in[`CMP_RISE_POS];
      next_fall_flag = wr_data_in[`CMP_FALL_POS];
      next_pos_hyst  = hyst_sel_t'(wr_data_in[`CMP_PHYST_HI:`CMP_PHYST_LO]);
      next_neg_hyst  = hyst_sel_t'(wr_data_in[`CMP_NHYST_HI:`CMP_NHYST_LO]);
    end
    if (wr_mode)
    begin
      next_rise_ie = wr_data_in[`CMP_RISE_IE_POS];
      next_fall_ie = wr_data_in[`CMP_FALL_IE_POS];
      next_mode    = wr_data_in[`CMP_MODE_HI:`CMP_MODE_LO];
    end
    // Hardware set wins over a software clear in the same cycle
    if (rise_evt)
      next_rise_flag = 1'b1;
    if (fall_evt)
      next_fall_flag = 1'b1;
    // Latched pin is forced low while disabled; taking the next enable
    // drops it on the same edge as the write that cuts the supply
    next_latched = next_enable & (rise_evt | (cmp_latched_out & ~fall_evt));
  end

  // ***************************************************
  // Registers
  // ***************************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cmp_enable_bit    <= 1'b0;
      cmp_rise_flag     <= 1'b0;
      cmp_fall_flag     <= 1'b0;
      cmp_pos_hyst_sel  <= hyst_sel_t'(`CMP_HYST_RESET);
      cmp_neg_hyst_sel  <= hyst_sel_t'(`CMP_HYST_RESET);
      cmp_response_mode <= `CMP_MODE_RESET;
      cmp_rise_irq_en   <= 1'b0;
      cmp_fall_irq_en   <= 1'b0;
      cmp_latched_out   <= 1'b0;
    end
    else
    begin
      cmp_enable_bit    <= next_enable;
      cmp_rise_flag     <= next_rise_flag;
      cmp_fall_flag     <= next_fall_flag;
      cmp_pos_hyst_sel  <= next_pos_hyst;
      cmp_neg_hyst_sel  <= next_neg_hyst;
      cmp_response_mode <= next_mode;
      cmp_rise_irq_en   <= next_rise_ie;
      cmp_fall_irq_en   <= next_fall_ie;
      cmp_latched_out   <= next_latched;
    end
  end

  // ***************************************************
  // Status, interrupt and reset outputs
  // ***************************************************
  assign cmp_control_reg_out = {cmp_enable_bit, cmp_latched_out, cmp_rise_flag,
                                cmp_fall_flag, cmp_pos_hyst_sel, cmp_neg_hyst_sel};
  assign cmp_mode_reg_out = {2'h0, cmp_rise_irq_en, cmp_fall_irq_en, 2'h0,
                             cmp_response_mode};
  assign cmp_cfg_out = '{cmp_enable_bit, cmp_pos_hyst_sel, cmp_neg_hyst_sel,
                         cmp_response_mode};
  assign cmp_rise_irq_out = cmp_rise_flag & cmp_rise_irq_en;
  assign cmp_fall_irq_out = cmp_fall_flag & cmp_fall_irq_en;
  // Reset request acts on the synchronised low level
  assign cmp_reset_req_out = cmp_reset_src_en_in & cmp_enable_bit & ~cmp_latched_out;

  // ***************************************************
  // Assertions
  // ***************************************************
  sequence s_rise_seen;
    rise_evt && !cmp_rise_flag;
  endsequence

  // Input stays high for three more edges after rising while enabled
  sequence s_rise_held;
    cmp_enable_bit && $rose(cmp_analog_in) ##1 cmp_analog_in [*3];
  endsequence

  // Input stays low for three more edges after falling
  sequence s_fall_held;
    $fell(cmp_analog_in) ##1 !cmp_analog_in [*3];
  endsequence

  a_rise_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_rise_seen |=> cmp_rise_flag) else $error("rise flag not set");
  a_fall_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    fall_evt |=> cmp_fall_flag) else $error("fall flag not set");
  a_rise_flag_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmp_rise_flag && !wr_ctl |=> cmp_rise_flag) else $error("rise flag dropped");
  a_fall_flag_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmp_fall_flag && !wr_ctl |=> cmp_fall_flag) else $error("fall flag dropped");
  // A clearing write only sticks when no edge lands in the same cycle
  a_rise_flag_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_ctl && !wr_data_in[`CMP_RISE_POS] && !rise_evt |=> !cmp_rise_flag)
    else $error("rise flag not cleared");
  a_fall_flag_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_ctl && !wr_data_in[`CMP_FALL_POS] && !fall_evt |=> !cmp_fall_flag)
    else $error("fall flag not cleared");
  a_rise_irq_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmp_rise_irq_out |-> cmp_rise_irq_en && cmp_rise_flag) else $error("rise irq ungated");
  a_fall_irq_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    cmp_fall_irq_out |-> cmp_fall_irq_en && cmp_fall_flag) else $error("fall irq ungated");
  a_disabled_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !cmp_enable_bit |-> !cmp_raw_out && !cmp_latched_out && !cmp_power_en_out)
    else $error("outputs not low while disabled");
  a_latch_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_rise_held |=> ##[0:1] cmp_latched_out || !cmp_enable_bit)
    else $error("latched output late");
  a_latch_drops: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_fall_held |=> ##[0:1] !cmp_latched_out)
    else $error("latched output not dropped");
  a_reset_on_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_fall_held ##0 (cmp_reset_src_en_in && cmp_enable_bit) |=> ##[0:1]
    (cmp_reset_req_out || !cmp_enable_bit || !cmp_reset_src_en_in))
    else $error("no reset request on low result");
  a_enable_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_ctl |=> cmp_enable_bit == $past(wr_data_in[`CMP_EN_POS])) else $error("enable bad");
  a_power_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_ctl |=> cmp_power_en_out == $past(wr_data_in[`CMP_EN_POS])) else $error("power bad");
  a_hyst_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_ctl |=> {cmp_pos_hyst_sel, cmp_neg_hyst_sel} == $past(wr_data_in[3:0]))
    else $error("hysteresis not written");
  a_mode_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_mode |=> cmp_response_mode == $past(wr_data_in[`CMP_MODE_HI:`CMP_MODE_LO]))
    else $error("response mode not written");
  a_irq_en_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_mode |=> {cmp_rise_irq_en, cmp_fall_irq_en} ==
      $past(wr_data_in[`CMP_RISE_IE_POS:`CMP_FALL_IE_POS]))
    else $error("irq enables not written");
endmodule // comparator_edge_control
`default_nettype wire
